// file: logic/iqsbf_top.sv
`timescale 1ns/100ps
module iqsbf_top (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trigIn,
    output logic [iqsbf_pkg::DAC_W-1:0] dacI,
    output logic [iqsbf_pkg::DAC_W-1:0] dacQ,
    output logic [iqsbf_pkg::SAMP_W-1:0] digI,
    output logic [iqsbf_pkg::SAMP_W-1:0] digQ,
    output logic [1:0] markerI,
    output logic [1:0] markerQ,
    output logic sampleRunning
);
    import iqsbf_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // rounds to res bits, saturates at top, clears bits below
    function automatic logic [15:0] reduceRes(input logic [15:0] s, input logic [4:0] res);
        logic [16:0] sum;
        logic [15:0] mask;
        sum = 17'h00000;
        mask = 16'hFFFF << (5'd16 - res);
        if (res >= RES_MAX) begin
            return s;
        end
        sum = {1'b0, s} + (17'h08000 >> res);
        if (sum[16]) begin
            sum = 17'h0FFFF;
        end
        return sum[15:0] & mask;
    endfunction : reduceRes

    function automatic logic [4:0] clampRes(input logic [4:0] v, input logic [4:0] hi);
        if (v < RES_MIN) begin
            return RES_MIN;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : clampRes

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic accWr;
    logic accRd;
    logic known;
    assign accWr = psel && penable && pready && pwrite;
    assign accRd = psel && penable && !pready;
    assign known = (paddr == OFF_CTRL) || (paddr == OFF_LOADADDR) ||
                   (paddr == OFF_LOADDATA) || (paddr == OFF_IDLE) ||
                   (paddr == OFF_RES) || (paddr == OFF_MARKER) ||
                   (paddr == OFF_STATUS) || (paddr == OFF_SEGSTART) ||
                   (paddr == OFF_SEGLEN) || (paddr == OFF_CHECKSUM);

    logic wrCtrl, wrAddr, wrData, wrIdle, wrRes, wrMark, wrStat, wrSegS, wrSegL, wrCs;
    assign wrCtrl = accWr && paddr == OFF_CTRL;
    assign wrAddr = accWr && paddr == OFF_LOADADDR;
    assign wrData = accWr && paddr == OFF_LOADDATA;
    assign wrIdle = accWr && paddr == OFF_IDLE;
    assign wrRes = accWr && paddr == OFF_RES;
    assign wrMark = accWr && paddr == OFF_MARKER;
    assign wrStat = accWr && paddr == OFF_STATUS;
    assign wrSegS = accWr && paddr == OFF_SEGSTART;
    assign wrSegL = accWr && paddr == OFF_SEGLEN;
    assign wrCs = accWr && paddr == OFF_CHECKSUM;

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic runEn_r;
    logic gatedMode_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            runEn_r <= 1'b0;
            gatedMode_r <= 1'b0;
        end else if (wrCtrl) begin
            runEn_r <= pwdata[CTRL_RUN];
            gatedMode_r <= pwdata[CTRL_GATED];
        end
    end

    // idle pair only changes when software supplies one
    logic [15:0] idleI_r;
    logic [15:0] idleQ_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            idleI_r <= IDLE_RST;
            idleQ_r <= IDLE_RST;
        end else if (wrIdle) begin
            idleI_r <= pwdata[15:0];
            idleQ_r <= pwdata[31:16];
        end
    end

    // generation and output resolution, clamped on write
    logic [4:0] genRes_r;
    logic [4:0] outRes_r;
    logic [4:0] genNxt;
    assign genNxt = clampRes(pwdata[RES_GEN_LSB +: 5], RES_MAX);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            genRes_r <= RES_MAX;
            outRes_r <= RES_MAX;
        end else if (wrRes) begin
            genRes_r <= genNxt;
            outRes_r <= clampRes(pwdata[RES_OUT_LSB +: 5], genNxt);
        end
    end

    // markers: refused while generation is 16 bits
    logic markOn_r;
    logic markRej_r;
    logic gen16;
    assign gen16 = (genRes_r == GEN_NOMARK);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            markOn_r <= 1'b0;
        end else if (wrRes && genNxt == GEN_NOMARK) begin
            markOn_r <= 1'b0;
        end else if (wrMark && !gen16) begin
            markOn_r <= pwdata[MARKER_EN];
        end else if (gen16) begin
            markOn_r <= 1'b0;
        end
    end

    // sticky reject flag; a new reject beats a clear in the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            markRej_r <= 1'b0;
        end else if (wrMark && gen16) begin
            markRej_r <= 1'b1;
        end else if (wrStat && pwdata[ST_MARKREJ]) begin
            markRej_r <= 1'b0;
        end
    end

    // segment window in I/Q pairs, not bytes
    logic [ADDR_W-1:0] segStart_r;
    logic [ADDR_W:0] segLen_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            segStart_r <= '0;
            segLen_r <= '0;
        end else begin
            if (wrSegS) begin
                segStart_r <= pwdata[ADDR_W-1:0];
            end
            if (wrSegL) begin
                segLen_r <= pwdata[ADDR_W:0];
            end
        end
    end

    // ----------------------------------------
    // load stream: byte assembly and buffer write
    // ----------------------------------------
    iqsbf_phase_type phase_r;
    logic [ADDR_W-1:0] loadPtr_r;
    logic [7:0] lowByte_r;
    logic [15:0] holdI_r;
    logic memWr;
    logic [31:0] memWdata;
    assign memWr = wrData && phase_r == PH_QHI;
    assign memWdata = {pwdata[7:0], lowByte_r, holdI_r}; // Q in top half, I in bottom

    // a new start address also resyncs the stream to an I low byte
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= PH_ILO;
        end else if (wrAddr) begin
            phase_r <= PH_ILO;
        end else if (wrData) begin
            unique case (phase_r)
                PH_ILO: phase_r <= PH_IHI;
                PH_IHI: phase_r <= PH_QLO;
                PH_QLO: phase_r <= PH_QHI;
                PH_QHI: phase_r <= PH_ILO;
                default: phase_r <= PH_ILO;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lowByte_r <= 8'h00;
            holdI_r <= 16'h0000;
        end else if (wrData) begin
            if (phase_r == PH_ILO || phase_r == PH_QLO) begin
                lowByte_r <= pwdata[7:0];
            end
            if (phase_r == PH_IHI) begin
                holdI_r <= {pwdata[7:0], lowByte_r};
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            loadPtr_r <= '0;
        end else if (wrAddr) begin
            loadPtr_r <= pwdata[ADDR_W-1:0];
        end else if (memWr) begin
            loadPtr_r <= loadPtr_r + 1'b1;
        end
    end

    // running checksum over the loaded pairs
    logic [31:0] csAcc_r;
    logic [31:0] csExp_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            csAcc_r <= CS_INIT;
            csExp_r <= 32'h00000000;
        end else begin
            if (wrAddr) begin
                csAcc_r <= CS_INIT;
            end else if (memWr) begin
                csAcc_r <= csAcc_r ^ memWdata;
            end
            if (wrCs) begin
                csExp_r <= pwdata;
            end
        end
    end
    logic csBad;
    assign csBad = (csExp_r != 32'h00000000) && (csAcc_r != csExp_r);

    // ----------------------------------------
    // trigger pin and playback
    // ----------------------------------------
    logic trigMeta_r;
    logic trigSync_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            trigMeta_r <= 1'b0;
            trigSync_r <= 1'b0;
        end else begin
            trigMeta_r <= trigIn;
            trigSync_r <= trigMeta_r;
        end
    end

    // gated mode only outputs while the trigger level is high
    logic playing;
    assign playing = runEn_r && (!gatedMode_r || trigSync_r);

    logic [ADDR_W-1:0] playPtr_r;
    logic [ADDR_W:0] playCnt_r;
    logic segEnd;
    assign segEnd = (segLen_r != '0) && (playCnt_r + 1'b1 >= segLen_r);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            playPtr_r <= '0;
            playCnt_r <= '0;
        end else if (!playing) begin
            playPtr_r <= segStart_r;
            playCnt_r <= '0;
        end else if (segEnd) begin
            playPtr_r <= segStart_r;
            playCnt_r <= '0;
        end else begin
            playPtr_r <= playPtr_r + 1'b1;
            playCnt_r <= playCnt_r + 1'b1;
        end
    end

    logic [31:0] memRdata;
    iqsbf_mem u_mem (
        .mclk(mclk),
        .wrEn(memWr),
        .wrAddr(loadPtr_r),
        .wrData(memWdata),
        .rdAddr(playPtr_r),
        .rdData(memRdata)
    );

    // read data lags the address by one cycle
    logic playD_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            playD_r <= 1'b0;
        end else begin
            playD_r <= playing;
        end
    end

    // ----------------------------------------
    // output formatting
    // ----------------------------------------
    logic [15:0] srcI;
    logic [15:0] srcQ;
    logic [15:0] redI;
    logic [15:0] redQ;
    assign srcI = (playD_r && playing) ? memRdata[15:0] : idleI_r;
    assign srcQ = (playD_r && playing) ? memRdata[31:16] : idleQ_r;
    assign redI = reduceRes(srcI, outRes_r);
    assign redQ = reduceRes(srcQ, outRes_r);

    // at 16 bits output the word passes untouched
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            digI <= IDLE_RST;
            digQ <= IDLE_RST;
            dacI <= IDLE_RST[SAMP_W-1:DAC_LSB];
            dacQ <= IDLE_RST[SAMP_W-1:DAC_LSB];
            sampleRunning <= 1'b0;
        end else begin
            digI <= redI;
            digQ <= redQ;
            dacI <= redI[SAMP_W-1:DAC_LSB];
            dacQ <= redQ[SAMP_W-1:DAC_LSB];
            sampleRunning <= playD_r && playing;
        end
    end

    // marker bits only while markers are allowed and on
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            markerI <= 2'b00;
            markerQ <= 2'b00;
        end else if (markOn_r && playD_r && playing) begin
            markerI <= memRdata[1:0];
            markerQ <= memRdata[17:16];
        end else begin
            markerI <= 2'b00;
            markerQ <= 2'b00;
        end
    end

    // ----------------------------------------
    // bus answer, one wait state
    // ----------------------------------------
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h00000000;
        unique case (paddr)
            OFF_CTRL: rdMux = {30'h0, gatedMode_r, runEn_r};
            OFF_LOADADDR: rdMux = {{(32-ADDR_W){1'b0}}, loadPtr_r};
            OFF_IDLE: rdMux = {idleQ_r, idleI_r};
            OFF_RES: rdMux = {19'h0, outRes_r, 3'h0, genRes_r};
            OFF_MARKER: rdMux = {31'h0, markOn_r};
            OFF_STATUS: rdMux = {{(16-ADDR_W){1'b0}}, loadPtr_r, 12'h0,
                                 csBad, markRej_r, markOn_r, sampleRunning};
            OFF_SEGSTART: rdMux = {{(32-ADDR_W){1'b0}}, segStart_r};
            OFF_SEGLEN: rdMux = {{(31-ADDR_W){1'b0}}, segLen_r};
            OFF_CHECKSUM: rdMux = csAcc_r;
            default: rdMux = 32'h00000000;
        endcase
    end

    // ready rises the cycle after penable; writes act on the edge that ends the ready cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (accRd) begin
            pready <= 1'b1;
            pslverr <= !known;
            prdata <= pwrite ? 32'h00000000 : rdMux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end
endmodule : iqsbf_top

// file: logic/iqsbf_pkg.sv
package iqsbf_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int ADDR_W = 12;                 // pair addresses in sample buffer
    localparam int SAMP_W = 16;
    localparam int DAC_W = 14;
    localparam int DAC_LSB = 2;                 // converter takes bits 2..15
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LOADADDR = 8'h04;
    localparam logic [7:0] OFF_LOADDATA = 8'h08;
    localparam logic [7:0] OFF_IDLE = 8'h0C;
    localparam logic [7:0] OFF_RES = 8'h10;
    localparam logic [7:0] OFF_MARKER = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_SEGSTART = 8'h1C;
    localparam logic [7:0] OFF_SEGLEN = 8'h20;
    localparam logic [7:0] OFF_CHECKSUM = 8'h24;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_GATED = 1;
    localparam int RES_GEN_LSB = 0;
    localparam int RES_OUT_LSB = 8;
    localparam int MARKER_EN = 0;
    localparam int ST_RUNNING = 0;
    localparam int ST_MARKON = 1;
    localparam int ST_MARKREJ = 2;
    localparam int ST_CSBAD = 3;
    localparam int ST_PTR_LSB = 16;
    // ----------------------------------------
    // reset values and codes
    // ----------------------------------------
    localparam logic [15:0] IDLE_RST = 16'h8000;     // mid-scale, zero level
    localparam logic [4:0] RES_MIN = 5'd8;
    localparam logic [4:0] RES_MAX = 5'd16;
    localparam logic [4:0] GEN_NOMARK = 5'd16;
    localparam logic [31:0] CS_INIT = 32'hA50F74FF;
    // byte phase of the load stream
    typedef enum logic [3:0] {
        PH_ILO = 4'b0001,
        PH_IHI = 4'b0010,
        PH_QLO = 4'b0100,
        PH_QHI = 4'b1000
    } iqsbf_phase_type;
endpackage : iqsbf_pkg

// file: logic/iqsbf_mem.sv
`timescale 1ns/100ps
// ----------------------------------------
// sample pair store, one write and one read port
// ----------------------------------------
module iqsbf_mem (
    input wire logic mclk,
    input wire logic wrEn,
    input wire logic [iqsbf_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [31:0] wrData,
    input wire logic [iqsbf_pkg::ADDR_W-1:0] rdAddr,
    output logic [31:0] rdData
);
    import iqsbf_pkg::*;

    logic [31:0] store [0:(1<<ADDR_W)-1];

    // later writes simply overwrite earlier ones at the same address
    always_ff @(posedge mclk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
    end

    // registered read, one cycle latency
    always_ff @(posedge mclk) begin
        rdData <= store[rdAddr];
    end
endmodule : iqsbf_mem

// file: dv/iqsbf_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// port checks for the sample formatter
// ----------------------------------------
module iqsbf_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [iqsbf_pkg::DAC_W-1:0] dacI,
    input wire logic [iqsbf_pkg::DAC_W-1:0] dacQ,
    input wire logic [iqsbf_pkg::SAMP_W-1:0] digI,
    input wire logic [iqsbf_pkg::SAMP_W-1:0] digQ,
    input wire logic [1:0] markerI,
    input wire logic [1:0] markerQ,
    input wire logic sampleRunning
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // bus answer: one wait state, one-cycle strobe
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    answer_lat_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready not one cycle after access");
    rdata_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    // converter word is the top of the reduced sample
    dac_bits_a: assert property (dacI == digI[15:2] && dacQ == digQ[15:2])
        else $error("converter word not msb aligned");
    marker_quiet_a: assert property (!sampleRunning |-> markerI == 2'h0 && markerQ == 2'h0)
        else $error("markers while idle");
    reset_idle_a: assert property ($rose(nrst) |-> digI == 16'h8000 && digQ == 16'h8000)
        else $error("idle not mid-scale after reset");
    // idle pair only moves after a register write (four cycles allow the pipeline)
    idle_hold_a: assert property ((!sampleRunning && !(pready && pwrite)) [*4]
        |-> $stable(digI) && $stable(digQ))
        else $error("idle output moved");
endmodule : iqsbf_checker

bind iqsbf_top iqsbf_checker u_chk (.mclk, .nrst, .psel, .penable, .pwrite, .prdata, .pready,
    .pslverr, .dacI, .dacQ, .digI, .digQ, .markerI, .markerQ, .sampleRunning);

// file: dv/iqsbf_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// host that loads waveform data over apb
// ----------------------------------------
module iqsbf_host_model (
    input wire logic mclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import iqsbf_pkg::*;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err, output logic tmo);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        tmo = 1'b1;
        while (n < 16) begin
            @(posedge mclk);
            n++;
            if (pready === 1'b1) begin
                tmo = 1'b0;
                n = 16;
            end
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released data must not look held
    endtask : xfer
    // one pair: I before Q, low byte before high byte
    task automatic sendPair(input logic [15:0] i, input logic [15:0] q, output logic tmo);
        logic [31:0] r;
        logic e;
        logic t;
        logic [7:0] b [4];
        b = '{i[7:0], i[15:8], q[7:0], q[15:8]};
        tmo = 1'b0;
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, OFF_LOADDATA, {24'h0, b[k]}, r, e, t);
            tmo = tmo | t;
        end
    endtask : sendPair
endmodule : iqsbf_host_model

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    import iqsbf_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic trigIn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, sampleRunning;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [13:0] dacI, dacQ;
    logic [15:0] digI, digQ, idleI, idleQ;
    logic [1:0] markerI, markerQ;
    logic [15:0] mi [8];
    logic [15:0] mq [8];
    int num_errors = 0;
    int num_checks = 0;
    int seed = 90;
    // ----------------------------------------
    // clock, design and host
    // ----------------------------------------
    always #20 mclk = ~mclk;
    iqsbf_top u_dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .trigIn, .dacI, .dacQ, .digI, .digQ, .markerI, .markerQ,
        .sampleRunning);
    iqsbf_host_model u_host (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict;
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic hang(input logic t);
        if (t) begin
            num_errors++;
            print_verdict();
        end
    endtask : hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        logic t;
        u_host.xfer(w, a, d, r, e, t);
        hang(t);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        bus(1'b1, a, d, r, e);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        bus(1'b0, a, 32'h0, r, e);
        chk(r & m, x);
    endtask : rdc
    task automatic pair(input int a);
        logic t;
        u_host.sendPair(mi[a], mq[a], t);
        hang(t);
    endtask : pair
    // rounding: half an lsb up, saturate, clear unused bits
    function automatic logic [15:0] rnd(input logic [15:0] v, input int res);
        logic [16:0] t;
        if (res >= 16) return v;
        t = {1'b0, v} + (17'h1 << (15 - res));
        if (t[16]) t = 17'h0FFFF;
        return t[15:0] & (16'hFFFF << (16 - res));
    endfunction : rnd
    task automatic waitRun(input logic lvl);
        int n;
        n = 0;
        #1;
        while (sampleRunning !== lvl && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        hang(n == 40);
    endtask : waitRun
    // play a segment for eight cycles, then stop and look at idle
    task automatic play(input int st, input int len, input int res, input logic mk);
        wr(OFF_SEGSTART, st);
        wr(OFF_SEGLEN, len);
        wr(OFF_CTRL, 32'h1);
        waitRun(1'b1);
        for (int k = 0; k < 8; k++) begin
            chk(digI, rnd(mi[st + k % len], res));
            chk(digQ, rnd(mq[st + k % len], res));
            chk(markerI, mk ? mi[st + k % len][1:0] : 2'b00);
            chk(markerQ, mk ? mq[st + k % len][1:0] : 2'b00);
            @(posedge mclk);
            #1;
        end
        wr(OFF_CTRL, 32'h0);
        waitRun(1'b0);
        chk(digI, rnd(idleI, res));
    endtask : play
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        chk(digI, 16'h8000);
        chk(dacQ, 14'h2000);
        rdc(OFF_IDLE, 32'hFFFFFFFF, 32'h80008000);
        rdc(OFF_RES, 32'h1F1F, 32'h1010);
        idleI = 16'($random(seed));
        idleQ = 16'($random(seed));
        wr(OFF_IDLE, {idleQ, idleI});
        wr(OFF_LOADADDR, 32'h0);
        for (int i = 0; i < 8; i++) begin
            mi[i] = 16'($random(seed));
            mq[i] = 16'($random(seed));
            pair(i);
        end
        // overwrite two pairs: pair 2 near full scale, pair 3 with full-scale corners
        mi[2] = 16'hFD00;
        mq[2] = 16'h0300;
        mi[3] = 16'hFFFF;
        mq[3] = 16'h0000;
        wr(OFF_LOADADDR, 32'h2);
        pair(2);
        pair(3);
        rdc(OFF_LOADADDR, 32'hFFF, 32'h4);
        chk(digI, idleI);
        play(1, 4, 16, 1'b0);
        wr(OFF_RES, 32'h0E0E);
        wr(OFF_MARKER, 32'h1);
        rdc(OFF_STATUS, 32'h2, 32'h2);
        play(0, 8, 14, 1'b1);
        wr(OFF_RES, 32'h1010);
        rdc(OFF_STATUS, 32'h2, 32'h0);
        wr(OFF_MARKER, 32'h1);
        rdc(OFF_STATUS, 32'h6, 32'h4);
        play(2, 2, 16, 1'b0);
        wr(OFF_RES, 32'h0A10);
        play(0, 4, 10, 1'b0);
        wr(OFF_RES, 32'h100C);
        rdc(OFF_RES, 32'h1F1F, 32'h0C0C);
        // running xor covers only the pairs since the last start address
        rdc(OFF_CHECKSUM, 32'hFFFFFFFF, CS_INIT ^ {mq[2], mi[2]} ^ {mq[3], mi[3]});
        wr(OFF_CHECKSUM, 32'h1);
        rdc(OFF_STATUS, 32'h8, 32'h8);
        wr(OFF_CHECKSUM, 32'h0);
        rdc(OFF_STATUS, 32'h8, 32'h0);
        bus(1'b0, 8'hFC, 32'h0, r, e);
        chk(e, 1'b1);
        chk(r, 32'h0);
        // gated play waits for the trigger, then runs
        wr(OFF_CTRL, 32'h3);
        repeat (6) @(posedge mclk);
        #1;
        chk(sampleRunning, 1'b0);
        chk(digI, rnd(idleI, 12));
        @(posedge mclk);
        trigIn <= 1'b1;
        waitRun(1'b1);
        chk(digQ, rnd(mq[0], 12));
        @(posedge mclk);
        trigIn <= 1'b0;
        waitRun(1'b0);
        // second reset in mid-run
        wr(OFF_CTRL, 32'h1);
        waitRun(1'b1);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk(digQ, 16'h8000);
        chk(sampleRunning, 1'b0);
        @(posedge mclk);
        nrst <= 1'b1;
        rdc(OFF_IDLE, 32'hFFFFFFFF, 32'h80008000);
        print_verdict();
    end
endmodule : testbench
